/* common/eirq_defs.svh */
`ifndef EIRQ_DEFS_SVH
`define EIRQ_DEFS_SVH
// Register byte addresses (printed offsets are not all multiples of four: index times four)
`define EIRQ_IDX_CH2_CONFIG 12'hFD9
`define EIRQ_IDX_CH3_CONFIG 12'hFDA
`define EIRQ_ADDR_CH2_CONFIG 14'h3F64
`define EIRQ_ADDR_CH3_CONFIG 14'h3F68
`define EIRQ_ADDR_IRQ_STATUS 14'h3F6C
`define EIRQ_ADDR_IRQ_MASK 14'h3F70
`define EIRQ_ADDR_CONTROL 14'h3F74
// Field positions inside a channel configuration register
`define EIRQ_LVL_BIT 4
`define EIRQ_TRIG_MSB 3
`define EIRQ_TRIG_LSB 2
`define EIRQ_RATE_MSB 1
`define EIRQ_RATE_LSB 0
// Reset values
`define EIRQ_CFG_RESET 8'h00
`define EIRQ_MASK_RESET 2'h0
`define EIRQ_CTRL_RESET 3'h0
// Trigger codes
`define EIRQ_TRIG_RISE 2'h0
`define EIRQ_TRIG_FALL 2'h1
`define EIRQ_TRIG_BOTH 2'h2
// Sample dividers: log2 for codes 01..11, slow divider
`define EIRQ_DIV_LOG_1 2
`define EIRQ_DIV_LOG_2 3
`define EIRQ_DIV_LOG_3 4
`define EIRQ_SLOW_DIV 4
// Filter agreement depth in samples
`define EIRQ_FILT_SAMPLES 2
`endif

/* common/eirq_pkg.sv */
package eirq_pkg;
    // Per-channel configuration fields
    typedef struct packed {
        logic capturedLevel;
        logic [1:0] triggerCondition;
        logic [1:0] filterSampleRate;
    } eirq_cfg_t;
    // AXI read answer state
    typedef enum logic [0:0] {EIRQ_RD_IDLE, EIRQ_RD_RESP} eirq_rd_state_t;
    // AXI write answer state
    typedef enum logic [1:0] {EIRQ_WR_IDLE, EIRQ_WR_RESP} eirq_wr_state_t;
    // Filter channel outward signals
    typedef struct packed {
        logic level;
        logic request;
    } eirq_chan_out_t;
endpackage

/* core/eirq_filter_chan.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eirq_defs.svh"
module eirq_filter_chan
    import eirq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstSync_n,
    input wire logic pinIn,
    input wire logic chanClockEnable,
    input wire logic slowMode,
    input wire logic lowFreqTick,
    input wire logic [1:0] sampleRate,
    input wire logic [1:0] triggerCondition,
    output eirq_pkg::eirq_chan_out_t chanOut
);
    // Whole channel state
    typedef struct packed {
        logic [2:0] sync;
        logic [3:0] divCnt;
        logic [1:0] slowCnt;
        logic [`EIRQ_FILT_SAMPLES-1:0] hist;
        logic filtered;
        logic request;
    } eirq_chan_state_t;
    eirq_chan_state_t st_q; // Registered state
    eirq_chan_state_t st_d; // Next state
    logic sampleTick; // Filter sample strobe
    logic pinLevel; // Synchronised pin level
    logic rise; // Filtered rising edge
    logic fall; // Filtered falling edge
    // Next state logic
    always_comb
    begin
        st_d = st_q;
        st_d.request = 1'b0;
        sampleTick = 1'b0;
        // Change counts once the second and third stages agree
        pinLevel = (st_q.sync[1] == st_q.sync[2]) ? st_q.sync[2] : st_q.filtered;
        st_d.sync = {st_q.sync[1:0], pinIn};
        if (slowMode)
        begin
            // Slow modes: low-frequency clock divided by four
            if (lowFreqTick)
            begin
                st_d.slowCnt = st_q.slowCnt + 2'h1;
                sampleTick = (st_q.slowCnt == 2'(`EIRQ_SLOW_DIV - 1));
            end
        end
        else
        begin
            // Fast modes: gear clock divided by 1, 4, 8 or 16
            st_d.divCnt = st_q.divCnt + 4'h1;
            case (sampleRate)
                2'h0: sampleTick = 1'b1;
                2'h1: sampleTick = (st_q.divCnt[`EIRQ_DIV_LOG_1-1:0] == '1);
                2'h2: sampleTick = (st_q.divCnt[`EIRQ_DIV_LOG_2-1:0] == '1);
                default: sampleTick = (st_q.divCnt[`EIRQ_DIV_LOG_3-1:0] == '1);
            endcase
        end
        rise = 1'b0;
        fall = 1'b0;
        if (sampleTick)
        begin
            st_d.hist = {st_q.hist[`EIRQ_FILT_SAMPLES-2:0], pinLevel};
            // Level passes only when all samples agree
            if (st_d.hist == '1)
            begin
                st_d.filtered = 1'b1;
                rise = !st_q.filtered;
            end
            else if (st_d.hist == '0)
            begin
                st_d.filtered = 1'b0;
                fall = st_q.filtered;
            end
        end
        // Edge selection
        case (triggerCondition)
            `EIRQ_TRIG_RISE: st_d.request = rise;
            `EIRQ_TRIG_FALL: st_d.request = fall;
            `EIRQ_TRIG_BOTH: st_d.request = rise | fall;
            default: st_d.request = 1'b0;
        endcase
        // Stopped clock holds the channel frozen
        if (!chanClockEnable)
        begin
            st_d = st_q;
            st_d.request = 1'b0;
        end
    end
    // State register
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    assign chanOut.level = st_q.filtered;
    assign chanOut.request = st_q.request;
endmodule
`default_nettype wire

/* core/eirq_ext_irq_ch23.sv */
// Summary of operation
// - Bit 4 captures filtered level at request
// - Captured level zero after reset, else level
// - Trigger code 00 requests on rising edge
// - Trigger code 01 requests on falling edge
// - Code 10 both edges; 11 reserved
// - Fast modes sample gear clock /1,/4,/8,/16
// - Slow modes sample low-frequency clock /4
// - Bits 7 to 5 read zero
// - Captured level refreshed at every request
// - Clock enable low stops channel, invalidates config
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "eirq_defs.svh"
module eirq_ext_irq_ch23
    import eirq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [13:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [13:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_irq_ch2,
    input wire logic ext_irq_ch3,
    input wire logic lowFreqClock,
    output logic [1:0] chanRequest,
    output logic irq
);
    import eirq_pkg::*;
    // Whole top-level state
    typedef struct packed {
        eirq_cfg_t [1:0] cfg;
        logic [1:0] status;
        logic [1:0] mask;
        logic [2:0] ctrl;
        logic [2:0] lfSync;
        logic lfLevel;
        logic awHeld;
        logic [13:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        eirq_wr_state_t wrState;
        logic bErr;
        eirq_rd_state_t rdState;
        logic [31:0] rData;
        logic rErr;
    } eirq_top_state_t;
    eirq_top_state_t st_q; // Registered state
    eirq_top_state_t st_d; // Next state
    logic [1:0] rstPipe_q; // Reset release synchroniser
    logic rstSync_n; // Synchronised reset
    logic [1:0] pins; // Pin inputs per channel
    eirq_chan_out_t [1:0] chanOut; // Filter outputs
    logic [1:0] chanClockEnable; // Per-channel clock enable
    logic slowMode; // Slow or sleep mode selected
    logic lowFreqTick; // One-cycle pulse per low-frequency rising edge
    logic wrFire; // Write executes this cycle
    logic [31:0] wrMasked; // Low write byte gated by strobe 0, upper bytes zero
    // Reads a register word for an address; flags unmapped
    function automatic logic [32:0] eirq_read(input eirq_top_state_t s, input logic [13:0] a);
        logic [32:0] r;
        r = '0;
        case (a)
            `EIRQ_ADDR_CH2_CONFIG: r[4:0] = s.cfg[0];
            `EIRQ_ADDR_CH3_CONFIG: r[4:0] = s.cfg[1];
            `EIRQ_ADDR_IRQ_STATUS: r[1:0] = s.status;
            `EIRQ_ADDR_IRQ_MASK: r[1:0] = s.mask;
            `EIRQ_ADDR_CONTROL: r[2:0] = s.ctrl;
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction
    // Reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rstPipe_q <= 2'h0;
        else
            rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
    assign rstSync_n = rstPipe_q[1];
    assign pins = {ext_irq_ch3, ext_irq_ch2};
    assign chanClockEnable = st_q.ctrl[1:0];
    assign slowMode = st_q.ctrl[2];
    assign lowFreqTick = (st_q.lfSync[1] == st_q.lfSync[2]) && st_q.lfSync[2] && !st_q.lfLevel;
    assign wrFire = st_q.awHeld && st_q.wHeld && (st_q.wrState == EIRQ_WR_IDLE);
    // Strobe gating of the low byte
    assign wrMasked = {24'h0, st_q.wStrb[0] ? st_q.wData[7:0] : 8'h00};
    // Filter and edge detector per channel
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : gChan
            eirq_filter_chan uChan (
                .clk_sys(clk_sys),
                .rstSync_n(rstSync_n),
                .pinIn(pins[gi]),
                .chanClockEnable(chanClockEnable[gi]),
                .slowMode(slowMode),
                .lowFreqTick(lowFreqTick),
                .sampleRate(st_q.cfg[gi].filterSampleRate),
                .triggerCondition(st_q.cfg[gi].triggerCondition),
                .chanOut(chanOut[gi])
            );
        end
    endgenerate
    // Next state: bus slave, registers, interrupt status
    always_comb
    begin
        logic [32:0] rd;
        rd = '0;
        st_d = st_q;
        // Low-frequency clock sampled through three stages
        st_d.lfSync = {st_q.lfSync[1:0], lowFreqClock};
        if (st_q.lfSync[1] == st_q.lfSync[2])
            st_d.lfLevel = st_q.lfSync[2];
        // Address and data taken in either order
        if (s_axi_awvalid && !st_q.awHeld)
        begin
            st_d.awHeld = 1'b1;
            st_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.wHeld)
        begin
            st_d.wHeld = 1'b1;
            st_d.wData = s_axi_wdata;
            st_d.wStrb = s_axi_wstrb;
        end
        // Register write
        if (wrFire)
        begin
            st_d.awHeld = 1'b0;
            st_d.wHeld = 1'b0;
            st_d.wrState = EIRQ_WR_RESP;
            st_d.bErr = 1'b0;
            case (st_q.awAddr)
                `EIRQ_ADDR_CH2_CONFIG:
                    if (chanClockEnable[0])
                        st_d.cfg[0][3:0] = wrMasked[3:0];
                `EIRQ_ADDR_CH3_CONFIG:
                    if (chanClockEnable[1])
                        st_d.cfg[1][3:0] = wrMasked[3:0];
                `EIRQ_ADDR_IRQ_STATUS: st_d.status = st_q.status & ~wrMasked[1:0];
                `EIRQ_ADDR_IRQ_MASK: st_d.mask = wrMasked[1:0];
                `EIRQ_ADDR_CONTROL: st_d.ctrl = wrMasked[2:0];
                default: st_d.bErr = 1'b1;
            endcase
        end
        // Write response
        case (st_q.wrState)
            EIRQ_WR_RESP:
                if (s_axi_bready)
                    st_d.wrState = EIRQ_WR_IDLE;
            default: ;
        endcase
        // Read path
        case (st_q.rdState)
            EIRQ_RD_IDLE:
                if (s_axi_arvalid)
                begin
                    rd = eirq_read(st_q, s_axi_araddr);
                    st_d.rData = rd[31:0];
                    st_d.rErr = rd[32];
                    st_d.rdState = EIRQ_RD_RESP;
                end
            EIRQ_RD_RESP:
                if (s_axi_rready)
                    st_d.rdState = EIRQ_RD_IDLE;
            default: st_d.rdState = EIRQ_RD_IDLE;
        endcase
        // Disabled channel loses its configuration
        for (int i = 0; i < 2; i++)
        begin
            if (!st_d.ctrl[i])
                st_d.cfg[i] = 5'(`EIRQ_CFG_RESET);
            if (chanOut[i].request)
            begin
                st_d.cfg[i].capturedLevel = chanOut[i].level;
                st_d.status[i] = 1'b1; // Set wins over clear
            end
        end
    end
    // State register
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    // Bus handshake and data outputs
    assign s_axi_awready = !st_q.awHeld;
    assign s_axi_wready = !st_q.wHeld;
    assign s_axi_bvalid = (st_q.wrState == EIRQ_WR_RESP);
    assign s_axi_bresp = st_q.bErr ? 2'h2 : 2'h0;
    assign s_axi_arready = (st_q.rdState == EIRQ_RD_IDLE);
    assign s_axi_rvalid = (st_q.rdState == EIRQ_RD_RESP);
    assign s_axi_rdata = st_q.rData;
    assign s_axi_rresp = st_q.rErr ? 2'h2 : 2'h0;
    assign chanRequest = {chanOut[1].request, chanOut[0].request};
    assign irq = |(st_q.status & st_q.mask);

    // Captured level follows filtered level one cycle after a request
    AST_LVL_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        chanOut[0].request |=> st_q.cfg[0].capturedLevel == $past(chanOut[0].level))
        else $error("captured level wrong");
    AST_LVL_RESET: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        $rose(rstSync_n) |-> st_q.cfg[1].capturedLevel == 1'b0)
        else $error("captured level not zero after reset");
    AST_RISE_ONLY: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (st_q.cfg[0].triggerCondition == 2'h0) && chanOut[0].request |-> chanOut[0].level)
        else $error("rise mode fired on falling level");
    AST_FALL_ONLY: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (st_q.cfg[0].triggerCondition == 2'h1) && chanOut[0].request |-> !chanOut[0].level)
        else $error("fall mode fired on rising level");
    AST_RESERVED_QUIET: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        ($past(st_q.cfg[1].triggerCondition) == 2'h3) && $stable(st_q.cfg[1]) |-> !chanOut[1].request)
        else $error("reserved code raised a request");
    AST_HIGH_BITS_ZERO: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
        else $error("upper read bits not zero");
    AST_DISABLED_CLEARS: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        !st_q.ctrl[0] |=> st_q.cfg[0] == 5'h0)
        else $error("disabled channel kept configuration");
    // Unmasked request raises the interrupt line on the next cycle
    AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        chanOut[0].request && st_q.mask[0] |=> irq)
        else $error("irq mismatch");
    // Masked-off status keeps the interrupt line low
    AST_IRQ_MASKED: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        (st_q.mask == 2'h0) |-> !irq)
        else $error("irq raised while masked");
    // Enabled channel takes the written trigger and rate fields
    AST_CFG_LANDS: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        wrFire && (st_q.awAddr == `EIRQ_ADDR_CH2_CONFIG) && st_q.ctrl[0]
        |=> st_q.cfg[0][3:0] == $past(wrMasked[3:0]))
        else $error("config write lost");
    // Writing a one clears the status bit unless a new request sets it
    AST_STATUS_W1C: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        wrFire && (st_q.awAddr == `EIRQ_ADDR_IRQ_STATUS) && wrMasked[0] && !chanOut[0].request
        |=> !st_q.status[0])
        else $error("status bit not cleared");
    // Write answer holds until the master accepts it
    AST_BVALID_HOLD: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    // Read answer and its data hold until the master accepts them
    AST_RVALID_HOLD: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    // Write answer only follows an executed write
    AST_B_AFTER_WRITE: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        $rose(s_axi_bvalid) |-> $past(wrFire))
        else $error("write answer without write");
    // Request sets status, then cover points for the main scenarios
    AST_REQ_SETS_STATUS: assert property (@(posedge clk_sys) disable iff (!rstSync_n)
        chanOut[1].request |=> st_q.status[1])
        else $error("request lost");
    COV_REQ2: cover property (@(posedge clk_sys) disable iff (!rstSync_n) chanOut[0].request);
    COV_BOTH3: cover property (@(posedge clk_sys) disable iff (!rstSync_n)
        chanOut[1].request && st_q.cfg[1].triggerCondition == 2'h2);
    COV_SLOW: cover property (@(posedge clk_sys) disable iff (!rstSync_n) slowMode && chanOut[0].request);
    COV_IRQ: cover property (@(posedge clk_sys) disable iff (!rstSync_n) $rose(irq));
endmodule
`default_nettype wire

/* bench/eirq_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eirq_pin_model (
    input wire logic [1:0] pinLevel,
    output logic ext_irq_ch2,
    output logic ext_irq_ch3,
    output logic lowFreqClock
);
    // Board drivers follow the wanted level after a trace delay, off the clock edge
    assign #3 ext_irq_ch2 = pinLevel[0];
    assign #3 ext_irq_ch3 = pinLevel[1];
    // Low-frequency oscillator runs free, 80 ns period
    initial
    begin
        lowFreqClock = 1'b0;
        forever #40 lowFreqClock = ~lowFreqClock;
    end
endmodule
`default_nettype wire

/* bench/tb_ext_irq_edge_noise_filter_ch23.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eirq_defs.svh"
module tb_ext_irq_edge_noise_filter_ch23;
    import eirq_pkg::*;
    localparam logic [13:0] A_ST = `EIRQ_ADDR_IRQ_STATUS;
    localparam logic [13:0] A_MK = `EIRQ_ADDR_IRQ_MASK;
    localparam logic [13:0] A_CT = `EIRQ_ADDR_CONTROL;
    // Bus, pin and clock signals
    logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_irq_ch2, ext_irq_ch3, lowFreqClock, irq;
    logic [13:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, chanRequest, pinLevel, lvl;
    logic [1:0] br; // Last write response code
    int nFail = 0;
    int numChecks = 0;
    int lat;
    logic hit;
    logic [31:0] d;
    logic [1:0] r;
    eirq_ext_irq_ch23 DUT (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_ch2,
        .ext_irq_ch3, .lowFreqClock, .chanRequest, .irq);
    eirq_pin_model pins (.pinLevel, .ext_irq_ch2, .ext_irq_ch3, .lowFreqClock);
    // 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Compare and count
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp)
        begin
            nFail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic wrapUp;
        if (nFail == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Configuration register address of a channel
    function automatic logic [13:0] cfgA(input int ch);
        return ch ? `EIRQ_ADDR_CH3_CONFIG : `EIRQ_ADDR_CH2_CONFIG;
    endfunction
    // One write; entered right after a rising edge, leaves after one
    task automatic axiWrite(input logic [13:0] a, input logic [31:0] v);
        logic aw, w, b;
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 100 && !b; n++)
        begin
            @(negedge clk_sys);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            if (b) br = s_axi_bresp;
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        check("write answer", 1, b);
        @(posedge clk_sys);
    endtask
    // One read returning data and response
    task automatic axiRead(input logic [13:0] a, output logic [31:0] dv, output logic [1:0] rv);
        logic ar, v;
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        v = 1'b0;
        for (n = 0; n < 100 && !v; n++)
        begin
            @(negedge clk_sys);
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            dv = s_axi_rdata;
            rv = s_axi_rresp;
            @(posedge clk_sys);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check("read answer", 1, v);
        @(posedge clk_sys);
    endtask
    // Read and compare data with an OKAY answer
    task automatic rdChk(input string what, input logic [13:0] a, input logic [31:0] exp);
        axiRead(a, d, r);
        check(what, exp, d);
        check("rresp", 0, r);
    endtask
    // Toggle a pin and count cycles to the request pulse, 300 meaning none
    task automatic edgeReq(input int ch, output int l);
        pinLevel[ch] <= !pinLevel[ch];
        for (l = 0; l < 300; l++)
        begin
            @(negedge clk_sys);
            if (chanRequest[ch] === 1'b1) break;
        end
        @(posedge clk_sys);
    endtask
    // Interrupt line after the status or mask update has landed
    task automatic irqChk(input logic exp);
        repeat (2) @(negedge clk_sys);
        check("irq", exp, irq);
        @(posedge clk_sys);
    endtask
    // Hang guard, well beyond the expected run
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        nFail++;
        wrapUp();
    end
    // Main sequence
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 14'h0000;
        s_axi_araddr = 14'h0000;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        pinLevel = 2'h0;
        lvl = 2'h0;
        rst_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // Reset contents
        rdChk("ch2 config", cfgA(0), 0);
        rdChk("ch3 config", cfgA(1), 0);
        rdChk("status", A_ST, 0);
        rdChk("mask", A_MK, 0);
        // Unmapped place answers with a slave error
        axiRead(14'h0000, d, r);
        check("unmapped rresp", 2, r);
        axiWrite(14'h0000, 32'h0);
        check("unmapped bresp", 2, br);
        // Channel clock off: writes and pin edges have no effect
        axiWrite(cfgA(0), 32'h5);
        rdChk("gated config", cfgA(0), 0);
        edgeReq(0, lat);
        check("gated request", 0, lat < 300);
        edgeReq(0, lat);
        axiWrite(A_CT, 32'h3);
        check("bresp", 0, br);
        // Upper bits and level bit ignored on write
        axiWrite(cfgA(0), 32'hF6);
        rdChk("ch2 fields", cfgA(0), 32'h06);
        axiWrite(cfgA(1), 32'hE9);
        rdChk("ch3 fields", cfgA(1), 32'h09);
        // Trigger codes 00 to 10 on both channels, both edges each
        for (int ch = 0; ch < 2; ch++)
            for (int c = 0; c < 3; c++)
            begin
                axiWrite(A_MK, 0);
                axiWrite(cfgA(ch), c << 2);
                axiWrite(A_ST, 3);
                for (int e = 0; e < 2; e++)
                begin
                    edgeReq(ch, lat);
                    hit = (lat < 300);
                    check("request", (c == 2) || (c == e), hit);
                    if (hit) lvl[ch] = !e;
                    rdChk("level", cfgA(ch), {27'h0, lvl[ch], c[1:0], 2'h0});
                    rdChk("status", A_ST, 32'(hit) << ch);
                    axiWrite(A_ST, 3);
                end
            end
        // Unmasked status drives the interrupt line
        axiWrite(A_MK, 1);
        edgeReq(0, lat);
        irqChk(1);
        axiWrite(A_MK, 0);
        irqChk(0);
        axiWrite(A_MK, 1);
        irqChk(1);
        axiWrite(A_ST, 1);
        irqChk(0);
        rdChk("cleared status", A_ST, 0);
        // Sampling interval per rate code in fast mode
        for (int k = 0; k < 4; k++)
        begin
            axiWrite(A_MK, 0);
            axiWrite(cfgA(0), 8 + k);
            edgeReq(0, lat);
            check("rate latency", 1, lat >= (k ? 2 << k : 1) && lat <= 4 * (k ? 2 << k : 1) + 12);
        end
        // Slow mode samples the low-frequency clock by four
        axiWrite(cfgA(0), 8);
        axiWrite(A_CT, 7);
        repeat (96) @(posedge clk_sys);
        axiWrite(A_ST, 3);
        edgeReq(0, lat);
        check("slow latency", 1, lat >= 30 && lat < 300);
        axiWrite(A_CT, 3);
        repeat (8) @(posedge clk_sys);
        axiWrite(A_ST, 3);
        edgeReq(0, lat);
        check("fast latency", 1, lat < 16);
        // Gating one channel leaves the other intact
        axiWrite(A_CT, 2);
        rdChk("gated ch2", cfgA(0), 0);
        edgeReq(0, lat);
        check("gated request", 0, lat < 300);
        rdChk("live ch3", cfgA(1), {27'h0, lvl[1], 4'h8});
        wrapUp();
    end
endmodule
`default_nettype wire
